// file: hdl/lpdc_pkg.sv
/*
  Package for the logical device configuration bank: register indices,
  address fields, reset values, fixed bit masks and the packed carriers
  shared by the bank and its surroundings.
  Assumes an APB master in front and per-function logic behind it.
*/
package lpdc_pkg;

  typedef logic [7:0] lpdc_byte_t;

  // logical device numbers, carried in the address above the index
  localparam int NUM_DEV = 4;
  localparam logic [1:0] DEV_KBD = 2'h0;
  localparam logic [1:0] DEV_MOUSE = 2'h1;
  localparam logic [1:0] DEV_RTC = 2'h2;
  localparam logic [1:0] DEV_FDC = 2'h3;

  // byte address = {device, index, 2'b00}
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_DEV_LSB = 10;

  // register indices
  localparam lpdc_byte_t IDX_CFG_CTL = 8'h02;
  localparam lpdc_byte_t IDX_ACT = 8'h30;
  localparam lpdc_byte_t IDX_RANGE = 8'h31;
  localparam lpdc_byte_t IDX_BASE_HI = 8'h60;
  localparam lpdc_byte_t IDX_BASE_LO = 8'h61;
  localparam lpdc_byte_t IDX_CMD_HI = 8'h62;
  localparam lpdc_byte_t IDX_CMD_LO = 8'h63;
  localparam lpdc_byte_t IDX_IRQ_SEL = 8'h70;
  localparam lpdc_byte_t IDX_IRQ_TYPE = 8'h71;
  localparam lpdc_byte_t IDX_DMA0 = 8'h74;
  localparam lpdc_byte_t IDX_DMA1 = 8'h75;
  localparam lpdc_byte_t IDX_FUNC_CFG = 8'hF0;
  localparam lpdc_byte_t IDX_DRIVE_ID = 8'hF1;

  // bit positions
  localparam int SOFT_RESET_BIT = 0;
  localparam int ACT_BIT = 0;
  localparam int TYPE_LEVEL_BIT = 0;
  localparam int TYPE_POL_BIT = 1;

  // reset values; the arrays are indexed by logical device
  localparam lpdc_byte_t ZERO_RST = 8'h00;
  localparam lpdc_byte_t BASE_HI_RST [NUM_DEV] = '{8'h00, 8'h00, 8'h00, 8'h03};
  localparam lpdc_byte_t BASE_LO_RST [NUM_DEV] = '{8'h60, 8'h00, 8'h70, 8'hF2};
  localparam lpdc_byte_t CMD_HI_RST = 8'h00;
  localparam lpdc_byte_t CMD_LO_RST = 8'h64;
  localparam lpdc_byte_t IRQ_SEL_RST [NUM_DEV] = '{8'h01, 8'h0C, 8'h08, 8'h06};
  localparam lpdc_byte_t IRQ_TYPE_RST [NUM_DEV] = '{8'h02, 8'h02, 8'h00, 8'h03};
  localparam lpdc_byte_t FDC_DMA_RST = 8'h02;
  localparam lpdc_byte_t DMA_NONE = 8'h04;
  localparam lpdc_byte_t KBD_CFG_RST = 8'h00;
  localparam lpdc_byte_t FDC_CFG_RST = 8'h00;
  localparam lpdc_byte_t DRIVE_ID_RST = 8'h00;

  // fixed bits: RO mask marks read-only bits, value gives what they read; WR mask marks writable bits
  localparam lpdc_byte_t BASE_LO_RO_MASK [NUM_DEV] = '{8'h04, 8'h00, 8'h01, 8'h05};
  localparam lpdc_byte_t BASE_LO_RO_VAL [NUM_DEV] = '{8'h00, 8'h00, 8'h00, 8'h00};
  localparam lpdc_byte_t CMD_LO_RO_MASK = 8'h04;
  localparam lpdc_byte_t CMD_LO_RO_VAL = 8'h04;
  localparam lpdc_byte_t IRQ_TYPE_WR_MASK [NUM_DEV] = '{8'h03, 8'h03, 8'h02, 8'h02};
  localparam lpdc_byte_t DMA_CH_MASK = 8'h07;

  // one bit per logical device, device 0 in bit 0
  typedef struct packed {
    logic fdc;
    logic rtc;
    logic mouse;
    logic kbd;
  } lpdc_dev_s;

  // host i/o cycle presented for address decode
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } lpdc_io_req_s;

  // decoded i/o selects
  typedef struct packed {
    logic fdc;
    logic rtc;
    logic kbd_cmd;
    logic kbd_data;
  } lpdc_hit_s;

endpackage

// file: hdl/lpdc_bank.sv
/*
  Plug and play configuration bank for four logical devices: keyboard,
  mouse, clock with its power control unit, and floppy controller.
  Holds activate, range check, base, interrupt and dma registers, decodes
  host i/o cycles and routes the device interrupt requests onto 15 lines.
  Assumes an APB master on mclk, synchronous inputs, and that the power
  management block supplies the function enable bits.
*/
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps

// Contract
// - keyboard activate resets per strap, gated by enable
// - keyboard data base 0060, bit 2 reads 0
// - keyboard command base 0064, bit 2 reads 1
// - keyboard irq select resets to 01
// - keyboard irq type 02, bits 1:0 writable
// - non-floppy dma registers read-only 04
// - inactive mouse never asserts its irq line
// - mouse activate leaves aux port handling alone
// - mouse irq select resets to 0C
// - mouse irq type 02, bits 1:0 writable
// - clock power unit ignores activate; strap reset
// - clock base 0070, bit 0 reads 0
// - clock irq select 08, type 00, bit1 writable
// - floppy base 03F2, bits 2 and 0 read 0
// - floppy irq select 06, type 03, bit1 writable
// - keyboard config survives soft reset
// - floppy config and drive id survive soft reset
// - control bit 0 soft reset; rst hard reset
// - type bit0 edge/level, bit1 polarity/drive; bit0 is stored but the router ignores it
// - dma channel 4 means no dma
module lpdc_bank (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_on_strap_select,
  input wire lpdc_pkg::lpdc_dev_s function_enable_one,
  input wire lpdc_pkg::lpdc_dev_s irq_req,
  input wire lpdc_pkg::lpdc_io_req_s io_req,
  output lpdc_pkg::lpdc_hit_s io_hit,
  output lpdc_pkg::lpdc_dev_s dev_enable,
  output logic aux_port_enable,
  output logic clock_power_control_unit_run,
  output logic [15:0] irq_level,
  output logic [15:0] irq_oe_n,
  output logic fdc_dma_active,
  output logic [2:0] fdc_dma_channel
);
  import lpdc_pkg::*;

  // per-device storage, addressed by logical device number
  lpdc_byte_t act_reg [NUM_DEV];
  lpdc_byte_t range_reg [NUM_DEV];
  lpdc_byte_t base_hi_reg [NUM_DEV];
  lpdc_byte_t base_lo_reg [NUM_DEV];
  lpdc_byte_t irq_sel_reg [NUM_DEV];
  lpdc_byte_t irq_type_reg [NUM_DEV];
  lpdc_byte_t cmd_hi_reg;
  lpdc_byte_t cmd_lo_reg;
  lpdc_byte_t fdc_dma_reg;
  lpdc_byte_t kbd_cfg_reg;
  lpdc_byte_t fdc_cfg_reg;
  lpdc_byte_t drive_id_reg;
  logic strap_reg;
  logic strap_done_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  lpdc_hit_s io_hit_reg;
  lpdc_dev_s dev_enable_reg;
  logic aux_port_enable_reg;
  logic pcu_run_reg;
  logic [15:0] irq_level_reg;
  logic [15:0] irq_oe_n_reg;
  logic fdc_dma_active_reg;
  logic [2:0] fdc_dma_channel_reg;

  logic [1:0] acc_dev;
  lpdc_byte_t acc_idx;
  logic wr_en;
  logic soft_rst;
  lpdc_byte_t wbyte;
  lpdc_byte_t rd_byte;
  logic rd_ok;
  logic [3:0] dev_en;
  logic [3:0] req_vec;

  // does this device implement this index
  function automatic logic reg_exists(input logic [1:0] dev, input lpdc_byte_t idx);
    logic ok;
    ok = 1'b0;
    case (idx)
      IDX_CFG_CTL, IDX_ACT, IDX_IRQ_SEL, IDX_IRQ_TYPE, IDX_DMA0, IDX_DMA1: ok = 1'b1;
      IDX_RANGE, IDX_BASE_HI, IDX_BASE_LO: ok = (dev != DEV_MOUSE);
      IDX_CMD_HI, IDX_CMD_LO: ok = (dev == DEV_KBD);
      IDX_FUNC_CFG: ok = (dev == DEV_KBD) || (dev == DEV_FDC);
      IDX_DRIVE_ID: ok = (dev == DEV_FDC);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // merge a write with fixed bits: mask marks bits that keep fixed_val
  function automatic lpdc_byte_t keep_fixed(input lpdc_byte_t wval, input lpdc_byte_t mask,
                                            input lpdc_byte_t fixed_val);
    return (wval & ~mask) | (fixed_val & mask);
  endfunction

  assign acc_dev = paddr[ADDR_DEV_LSB +: 2];
  assign acc_idx = paddr[ADDR_IDX_LSB +: 8];
  assign wbyte = pwdata[7:0];
  // writes land only on the edge that completes the access phase
  assign wr_en = psel && penable && pready_reg && pwrite && reg_exists(acc_dev, acc_idx);
  assign soft_rst = wr_en && (acc_idx == IDX_CFG_CTL) && wbyte[SOFT_RESET_BIT];
  assign dev_en = {act_reg[DEV_FDC][ACT_BIT], act_reg[DEV_RTC][ACT_BIT],
                   act_reg[DEV_MOUSE][ACT_BIT], act_reg[DEV_KBD][ACT_BIT]}
                  & function_enable_one;
  assign req_vec = irq_req;

  // strap is caught once, on the first edge after hard reset release
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strap_reg <= 1'b0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_reg <= power_on_strap_select;
      strap_done_reg <= 1'b1;
    end
  end

  // activate registers; the strap picks 00 or 01 for three devices
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int d = 0; d < NUM_DEV; d++) begin
        act_reg[d] <= ZERO_RST;
      end
    end else if (!strap_done_reg || soft_rst) begin
      act_reg[DEV_KBD] <= {7'h00, strap_done_reg ? strap_reg : power_on_strap_select};
      act_reg[DEV_MOUSE] <= ZERO_RST;
      act_reg[DEV_RTC] <= {7'h00, strap_done_reg ? strap_reg : power_on_strap_select};
      act_reg[DEV_FDC] <= {7'h00, strap_done_reg ? strap_reg : power_on_strap_select};
    end else if (wr_en && acc_idx == IDX_ACT) begin
      act_reg[acc_dev] <= wbyte;
    end
  end

  // base, range and interrupt registers; hard and soft reset match
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int d = 0; d < NUM_DEV; d++) begin
        range_reg[d] <= ZERO_RST;
        base_hi_reg[d] <= BASE_HI_RST[d];
        base_lo_reg[d] <= BASE_LO_RST[d];
        irq_sel_reg[d] <= IRQ_SEL_RST[d];
        irq_type_reg[d] <= IRQ_TYPE_RST[d];
      end
      cmd_hi_reg <= CMD_HI_RST;
      cmd_lo_reg <= CMD_LO_RST;
      fdc_dma_reg <= FDC_DMA_RST;
    end else if (soft_rst) begin
      for (int d = 0; d < NUM_DEV; d++) begin
        range_reg[d] <= ZERO_RST;
        base_hi_reg[d] <= BASE_HI_RST[d];
        base_lo_reg[d] <= BASE_LO_RST[d];
        irq_sel_reg[d] <= IRQ_SEL_RST[d];
        irq_type_reg[d] <= IRQ_TYPE_RST[d];
      end
      cmd_hi_reg <= CMD_HI_RST;
      cmd_lo_reg <= CMD_LO_RST;
      fdc_dma_reg <= FDC_DMA_RST;
    end else if (wr_en) begin
      case (acc_idx)
        IDX_RANGE: range_reg[acc_dev] <= wbyte;
        IDX_BASE_HI: base_hi_reg[acc_dev] <= wbyte;
        IDX_BASE_LO: base_lo_reg[acc_dev] <= keep_fixed(wbyte, BASE_LO_RO_MASK[acc_dev],
                                                        BASE_LO_RO_VAL[acc_dev]);
        IDX_CMD_HI: cmd_hi_reg <= wbyte;
        IDX_CMD_LO: cmd_lo_reg <= keep_fixed(wbyte, CMD_LO_RO_MASK, CMD_LO_RO_VAL);
        IDX_IRQ_SEL: irq_sel_reg[acc_dev] <= wbyte;
        IDX_IRQ_TYPE: irq_type_reg[acc_dev] <= keep_fixed(IRQ_TYPE_RST[acc_dev],
                                                          IRQ_TYPE_WR_MASK[acc_dev], wbyte);
        IDX_DMA0: begin
          if (acc_dev == DEV_FDC) begin
            fdc_dma_reg <= wbyte & DMA_CH_MASK;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // vendor configuration bytes: hard reset only, no soft reset path
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      kbd_cfg_reg <= KBD_CFG_RST;
      fdc_cfg_reg <= FDC_CFG_RST;
      drive_id_reg <= DRIVE_ID_RST;
    end else if (wr_en) begin
      if (acc_idx == IDX_FUNC_CFG && acc_dev == DEV_KBD) begin
        kbd_cfg_reg <= wbyte;
      end
      if (acc_idx == IDX_FUNC_CFG && acc_dev == DEV_FDC) begin
        fdc_cfg_reg <= wbyte;
      end
      if (acc_idx == IDX_DRIVE_ID && acc_dev == DEV_FDC) begin
        drive_id_reg <= wbyte;
      end
    end
  end

  // read mux; the control index reads back as zero
  always_comb begin
    rd_byte = 8'h00;
    rd_ok = reg_exists(acc_dev, acc_idx);
    case (acc_idx)
      IDX_ACT: rd_byte = act_reg[acc_dev];
      IDX_RANGE: rd_byte = range_reg[acc_dev];
      IDX_BASE_HI: rd_byte = base_hi_reg[acc_dev];
      IDX_BASE_LO: rd_byte = base_lo_reg[acc_dev];
      IDX_CMD_HI: rd_byte = cmd_hi_reg;
      IDX_CMD_LO: rd_byte = cmd_lo_reg;
      IDX_IRQ_SEL: rd_byte = irq_sel_reg[acc_dev];
      IDX_IRQ_TYPE: rd_byte = irq_type_reg[acc_dev];
      IDX_DMA0: rd_byte = (acc_dev == DEV_FDC) ? fdc_dma_reg : DMA_NONE;
      IDX_DMA1: rd_byte = DMA_NONE;
      IDX_FUNC_CFG: rd_byte = (acc_dev == DEV_FDC) ? fdc_cfg_reg : kbd_cfg_reg;
      IDX_DRIVE_ID: rd_byte = drive_id_reg;
      default: rd_byte = 8'h00;
    endcase
    if (!rd_ok) begin
      rd_byte = 8'h00;
    end
  end

  // apb slave: pready rises in the access phase, one wait-free cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready_reg <= 1'b1;
      pslverr_reg <= !reg_exists(acc_dev, acc_idx);
      prdata_reg <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end else begin
      // one-cycle answer, so a back-to-back setup sees pready low again
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // enables and host i/o decode, registered to keep outputs glitch free
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dev_enable_reg <= '0;
      aux_port_enable_reg <= 1'b0;
      pcu_run_reg <= 1'b0;
      io_hit_reg <= '0;
    end else begin
      dev_enable_reg <= dev_en;
      aux_port_enable_reg <= dev_en[DEV_KBD];
      pcu_run_reg <= 1'b1;
      io_hit_reg.kbd_data <= io_req.valid && dev_en[DEV_KBD]
                             && io_req.addr == {base_hi_reg[DEV_KBD], base_lo_reg[DEV_KBD]};
      io_hit_reg.kbd_cmd <= io_req.valid && dev_en[DEV_KBD]
                            && io_req.addr == {cmd_hi_reg, cmd_lo_reg};
      // clock answers a two-port pair, address bit 0 ignored
      io_hit_reg.rtc <= io_req.valid && dev_en[DEV_RTC]
                        && io_req.addr[15:1] == {base_hi_reg[DEV_RTC], base_lo_reg[DEV_RTC][7:1]};
      // floppy decodes an eight-port block
      io_hit_reg.fdc <= io_req.valid && dev_en[DEV_FDC]
                        && io_req.addr[15:3] == {base_hi_reg[DEV_FDC], base_lo_reg[DEV_FDC][7:3]};
    end
  end

  // floppy dma channel, with channel 4 treated as none
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fdc_dma_active_reg <= 1'b0;
      fdc_dma_channel_reg <= 3'h0;
    end else begin
      fdc_dma_active_reg <= dev_en[DEV_FDC] && (fdc_dma_reg != DMA_NONE);
      fdc_dma_channel_reg <= fdc_dma_reg[2:0];
    end
  end

  // interrupt router: line 0 means unrouted, so lines 1..15 only
  assign irq_level = irq_level_reg;
  assign irq_oe_n = irq_oe_n_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_level_reg[0] <= 1'b0;
      irq_oe_n_reg[0] <= 1'b1;
    end else begin
      irq_level_reg[0] <= 1'b0;
      irq_oe_n_reg[0] <= 1'b1;
    end
  end

  for (genvar l = 1; l < 16; l++) begin : g_line
    logic hit_act;
    logic push_pull;
    // a disabled device contributes nothing, so an inactive mouse is silent
    always_comb begin
      hit_act = 1'b0;
      push_pull = 1'b0;
      for (int d = 0; d < NUM_DEV; d++) begin
        if (dev_en[d] && irq_sel_reg[d][3:0] == 4'(l)) begin
          hit_act = hit_act | req_vec[d];
          push_pull = push_pull | irq_type_reg[d][TYPE_POL_BIT];
        end
      end
    end
    // high polarity drives the line always; low polarity only pulls it low
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        irq_level_reg[l] <= 1'b0;
        irq_oe_n_reg[l] <= 1'b1;
      end else begin
        irq_level_reg[l] <= push_pull ? hit_act : 1'b0;
        irq_oe_n_reg[l] <= push_pull ? 1'b0 : !hit_act;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign io_hit = io_hit_reg;
  assign dev_enable = dev_enable_reg;
  assign aux_port_enable = aux_port_enable_reg;
  assign clock_power_control_unit_run = pcu_run_reg;
  assign fdc_dma_active = fdc_dma_active_reg;
  assign fdc_dma_channel = fdc_dma_channel_reg;

endmodule

// file: bench/lpdc_bank_properties.sv
/*
  Port assertions for the configuration bank.
  Assumes one mclk domain, rst asynchronous active high, bound below.
*/
`timescale 1ns/1ps
module lpdc_props
  import lpdc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire lpdc_pkg::lpdc_dev_s function_enable_one,
  input wire lpdc_pkg::lpdc_dev_s irq_req,
  input wire lpdc_pkg::lpdc_io_req_s io_req,
  input wire lpdc_pkg::lpdc_hit_s io_hit,
  input wire lpdc_pkg::lpdc_dev_s dev_enable,
  input wire logic aux_port_enable,
  input wire logic clock_power_control_unit_run,
  input wire logic [15:0] irq_level,
  input wire logic [15:0] irq_oe_n,
  input wire logic fdc_dma_active,
  input wire logic [2:0] fdc_dma_channel
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // apb phases; the slave adds no wait states
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> s_access)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_quiet_lines_low: assert property ($past(irq_req) == 4'h0 |-> irq_level == 16'h0000)
    else $error("irq level without request");
  a_line_zero_idle: assert property (irq_oe_n[0] && !irq_level[0])
    else $error("line zero driven");
  a_enable_gated: assert property (dev_enable.kbd |-> $past(function_enable_one.kbd))
    else $error("keyboard enabled while gated off");
  a_aux_follows_kbd: assert property (aux_port_enable == dev_enable.kbd)
    else $error("aux port enable off keyboard enable");
  a_power_unit_runs: assert property (!$past(rst) |-> clock_power_control_unit_run)
    else $error("power control unit stopped");
  // decode answers only a sampled cycle
  a_hit_needs_req: assert property (io_hit != 4'h0 |-> $past(io_req.valid))
    else $error("io hit without request");
  a_hit_one_shot: assert property (io_hit != 4'h0 && !io_req.valid |=> io_hit == 4'h0)
    else $error("io hit held");
  a_dma_none_four: assert property (fdc_dma_active |-> fdc_dma_channel != 3'h4)
    else $error("dma active on cascade channel");
endmodule

bind lpdc_bank lpdc_props u_props (.mclk, .rst, .psel, .penable, .pready, .pslverr,
  .function_enable_one, .irq_req, .io_req, .io_hit, .dev_enable, .aux_port_enable,
  .clock_power_control_unit_run, .irq_level, .irq_oe_n, .fdc_dma_active, .fdc_dma_channel);

// file: bench/lpdc_host.sv
/*
  Host model: configuration software reaching the bank over apb.
  Assumes mclk from the bench; transfers are issued by calling xfer.
*/
`timescale 1ns/1ps
module lpdc_host (
  input wire logic mclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [15:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
  end
  // one transfer, held until pready is seen; only the bench watchdog ends a dead wait
  task automatic xfer(input logic wr, input logic [1:0] dev, input logic [7:0] idx,
      input logic [7:0] wd, output logic [7:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {4'h0, dev, idx, 2'h0};
    pwdata <= {24'h000000, wd};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata; // stale data must not look valid
  endtask
endmodule

// file: bench/testbench.sv
/*
  Self-checking bench for the configuration bank.
  Assumes the host model for apb; bench drives strap, enables, irq and io.
*/
`timescale 1ns/1ps
module testbench;
  import lpdc_pkg::*;
  logic mclk;
  logic rst;
  logic strap;
  lpdc_dev_s fen;
  lpdc_dev_s irq_req;
  lpdc_io_req_s io_req;
  logic psel, penable, pwrite, pready, pslverr, aux, pcu_run, dma_act;
  logic [15:0] paddr, irq_level, irq_oe_n;
  logic [31:0] pwdata, prdata;
  lpdc_hit_s io_hit;
  lpdc_dev_s dev_en;
  logic [2:0] dma_ch;
  logic [7:0] rd;
  logic err;
  int failures = 0;
  int n_checks = 0;
  lpdc_bank dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_on_strap_select(strap), .function_enable_one(fen), .irq_req(irq_req),
    .io_req(io_req), .io_hit(io_hit), .dev_enable(dev_en), .aux_port_enable(aux),
    .clock_power_control_unit_run(pcu_run), .irq_level(irq_level), .irq_oe_n(irq_oe_n),
    .fdc_dma_active(dma_act), .fdc_dma_channel(dma_ch));
  lpdc_host host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // {dev, index, value}, strap high
  logic [19:0] rst_tbl [$] = '{20'h03001, 20'h03100, 20'h06000, 20'h06160, 20'h06200,
    20'h06364, 20'h07001, 20'h07102, 20'h07404, 20'h07504, 20'h0F000, 20'h13000, 20'h1700C,
    20'h17102, 20'h17404, 20'h17504, 20'h23001, 20'h23100, 20'h26000, 20'h26170, 20'h27008,
    20'h27100, 20'h27404, 20'h27504, 20'h33001, 20'h33100, 20'h36003, 20'h361F2, 20'h37006,
    20'h37103, 20'h37402, 20'h37504, 20'h3F000, 20'h3F100};
  // {dev, index, written, read back}
  logic [27:0] fix_tbl [$] = '{28'h061FFFB, 28'h0630004, 28'h261FFFE, 28'h361FFFA,
    28'h071FF03, 28'h171FC00, 28'h271FF02, 28'h3710001, 28'h0740004, 28'h1750004,
    28'h2740704, 28'h374FF07, 28'h3750004, 28'h3605A5A};
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] d, input logic [7:0] i, input logic [7:0] v);
    host.xfer(1'b1, d, i, v, rd, err);
  endtask
  task automatic rdv(input logic [1:0] d, input logic [7:0] i);
    host.xfer(1'b0, d, i, 8'h00, rd, err);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic io_probe(input logic [15:0] a, input logic [3:0] exp);
    @(posedge mclk);
    io_req <= {1'b1, a};
    @(posedge mclk);
    io_req <= {1'b0, ~a}; // released address must not alias
    #1;
    chk($sformatf("hit at %h", a), io_hit, exp);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic t_reset_vals();
    foreach (rst_tbl[k]) begin
      rdv(rst_tbl[k][17:16], rst_tbl[k][15:8]);
      chk($sformatf("reg %h", rst_tbl[k][17:8]), rd, rst_tbl[k][7:0]);
    end
  endtask
  task automatic t_fixed_bits();
    foreach (fix_tbl[k]) begin
      wr(fix_tbl[k][25:24], fix_tbl[k][23:16], fix_tbl[k][15:8]);
      rdv(fix_tbl[k][25:24], fix_tbl[k][23:16]);
      chk($sformatf("reg %h", fix_tbl[k][25:16]), rd, fix_tbl[k][7:0]);
    end
    rdv(2'h1, 8'h60); // mouse has no base register
    chk("unmapped read error", err, 1'b1);
    chk("unmapped read data", rd, 8'h00);
  endtask
  task automatic t_soft_reset();
    wr(2'h0, 8'hF0, 8'h5A);
    wr(2'h3, 8'hF1, 8'h3C);
    wr(2'h0, 8'h70, 8'h05);
    wr(2'h0, 8'h02, 8'h01);
    rdv(2'h0, 8'h70);
    chk("kbd irq select", rd, 8'h01);
    rdv(2'h3, 8'h61);
    chk("fdc base low", rd, 8'hF2);
    rdv(2'h0, 8'hF0);
    chk("kbd config", rd, 8'h5A);
    rdv(2'h3, 8'hF1);
    chk("drive id", rd, 8'h3C);
  endtask
  task automatic t_irq();
    @(posedge mclk);
    irq_req <= 4'h3;
    cyc(3);
    chk("line 1 level", irq_level[1], 1'b1);
    chk("line 12 oe_n", irq_oe_n[12], 1'b1);
    wr(2'h1, 8'h30, 8'h01);
    wr(2'h0, 8'h71, 8'h00);
    cyc(3);
    chk("line 12 level", {irq_level[12], irq_oe_n[12]}, 2'h2);
    chk("line 1 open drain", {irq_level[1], irq_oe_n[1]}, 2'h0);
    @(posedge mclk);
    irq_req <= 4'h0;
    cyc(3);
    chk("line 1 released", irq_oe_n[1], 1'b1);
  endtask
  task automatic t_dma();
    cyc(1);
    chk("fdc dma", {dma_act, dma_ch}, 4'hA);
    wr(2'h3, 8'h74, 8'h04);
    cyc(2);
    chk("fdc dma none", dma_act, 1'b0);
  endtask
  task automatic t_io();
    io_probe(16'h0060, 4'h1);
    io_probe(16'h0064, 4'h2);
    io_probe(16'h0071, 4'h4);
    io_probe(16'h03F7, 4'h8);
    io_probe(16'h0061, 4'h0);
    wr(2'h2, 8'h30, 8'h00);
    wr(2'h1, 8'h30, 8'h00);
    io_probe(16'h0070, 4'h0);
    chk("power unit", pcu_run, 1'b1);
    chk("aux port", aux, 1'b1);
    @(posedge mclk);
    fen <= 4'hE;
    cyc(2);
    chk("kbd gated", dev_en.kbd, 1'b0);
    io_probe(16'h0060, 4'h0);
  endtask
  // mid-run hard reset with the strap low
  task automatic t_hard_reset();
    @(posedge mclk);
    rst <= 1'b1;
    strap <= 1'b0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    rdv(2'h0, 8'h30);
    chk("kbd activate strap low", rd, 8'h00);
    rdv(2'h2, 8'h30);
    chk("rtc activate strap low", rd, 8'h00);
    chk("power unit after reset", pcu_run, 1'b1);
    rdv(2'h0, 8'hF0);
    chk("kbd config hard reset", rd, 8'h00);
    rdv(2'h3, 8'hF1);
    chk("drive id hard reset", rd, 8'h00);
    rdv(2'h1, 8'h30);
    chk("mouse activate hard reset", rd, 8'h00);
  endtask
  initial begin
    rst = 1'b1;
    strap = 1'b1;
    fen = 4'hF;
    irq_req = 4'h0;
    io_req = 17'h00000;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_reset_vals();
    t_fixed_bits();
    t_soft_reset();
    t_irq();
    t_dma();
    t_io();
    t_hard_reset();
    give_verdict();
  end
  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    give_verdict();
  end
endmodule
